// ---- pkg/sarc_map.svh ----
`ifndef SARC_MAP_SVH
`define SARC_MAP_SVH
// clock period in ns (125 MHz)
`define SARC_CLK_NS 8
// conversion time, typical, in ns
`define SARC_CONV_NS 7000
`define SARC_CONV_CYC ((`SARC_CONV_NS + `SARC_CLK_NS - 1) / `SARC_CLK_NS)
// least start pulse width in ns, rounded up to cycles
`define SARC_START_NS 40
`define SARC_START_CYC ((`SARC_START_NS + `SARC_CLK_NS - 1) / `SARC_CLK_NS)
// least setup of convert select before chip select falls
`define SARC_SETUP_NS 10
`define SARC_SETUP_CYC ((`SARC_SETUP_NS + `SARC_CLK_NS - 1) / `SARC_CLK_NS)
// latest return of the start inputs after start, rounded down
`define SARC_RELEASE_NS 3000
`define SARC_RELEASE_CYC (`SARC_RELEASE_NS / `SARC_CLK_NS)
// least acquisition time in ns
`define SARC_ACQ_NS 2000
`define SARC_ACQ_CYC ((`SARC_ACQ_NS + `SARC_CLK_NS - 1) / `SARC_CLK_NS)
// result width and byte width
`define SARC_WIDTH 16
`define SARC_BYTE 8
// reset value of the output latches
`define SARC_RESULT_RST 16'h0000
`endif

// ---- pkg/sarc_pkg.sv ----
`include "sarc_map.svh"
package sarc_pkg;
  typedef logic [`SARC_WIDTH-1:0] sarc_word_type;
  typedef enum logic [1:0] {
    SARC_IDLE = 2'b00,
    SARC_CONV = 2'b01,
    SARC_DONE = 2'b10
  } sarc_dev_state_type;
  typedef enum logic [2:0] {
    SARC_H_IDLE = 3'b000,
    SARC_H_START = 3'b001,
    SARC_H_WAIT = 3'b010,
    SARC_H_READ = 3'b011,
    SARC_H_ACQ = 3'b100
  } sarc_host_state_type;
endpackage : sarc_pkg

// ---- pkg/sarc_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface sarc_if;
  import sarc_pkg::*;
  logic cs_n;
  logic read_conv;
  logic byte_sel;
  logic busy_n;
  sarc_word_type data_out;
  logic data_oe;
  // bus level as seen by the host; floating lanes read as zero here
  sarc_word_type data_bus;
  assign data_bus = data_oe ? data_out : '0;
  modport device (input cs_n, input read_conv, input byte_sel,
    output busy_n, output data_out, output data_oe);
  modport host (output cs_n, output read_conv, output byte_sel,
    input busy_n, input data_bus);
endinterface : sarc_if
`default_nettype wire

// ---- rtl/sarc_device.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sarc_map.svh"
module sarc_device
  import sarc_pkg::*;
#(
  parameter int CONV_CYCLES = `SARC_CONV_CYC,
  parameter bit BIPOLAR = 1'b0
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // host side
  sarc_if.device bus,
  // analog front end model: sampled input and hold flag
  input wire logic [`SARC_WIDTH-1:0] sample_in,
  output logic sample_hold
);
  // start detection
  logic start_gate;
  logic start_gate_q;
  logic start_req;
  logic take_start;
  // conversion progress
  sarc_dev_state_type state;
  logic decide;
  logic last_cycle;
  logic [15:0] cycle_count;
  logic [4:0] bit_index;
  // data path
  sarc_word_type approx_result_reg;
  sarc_word_type held_sample;
  sarc_word_type result_latch;
  sarc_word_type trial;
  logic [`SARC_WIDTH-1:0] cmp_value;

  // count value at which decision number index is made; the conversion is cut
  // into sixteen equal slots, so a short count for simulation still resolves
  // every bit, only faster
  function automatic logic [15:0] slot_edge(input logic [4:0] index);
    logic [31:0] slot_at;
    slot_at = 32'((CONV_CYCLES * (32'(index) + 1)) / `SARC_WIDTH - 1);
    return slot_at[15:0];
  endfunction : slot_edge

  // lane order of a read; with byte select high the low byte moves up, so a
  // host with an 8-bit port reads both halves through the upper lanes
  function automatic sarc_word_type lane_order(input sarc_word_type word, input logic swap);
    sarc_word_type order;
    order = word;
    if (swap) begin
      order = {word[`SARC_BYTE-1:0], word[`SARC_WIDTH-1:`SARC_BYTE]};
    end
    return order;
  endfunction : lane_order

  // ored start gate; low only while both selects are low
  assign start_gate = bus.cs_n | bus.read_conv;
  // a start is the falling edge of the combined gate, in either mode
  assign start_req = start_gate_q & ~start_gate;
  // a start counts only in idle; a gate that falls mid-conversion is dropped
  assign take_start = start_req && state == SARC_IDLE;

  // previous gate level; it resets to the idle level of the gate, so the
  // release of reset with the gate high is never taken for a falling edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      start_gate_q <= 1'b1;
    end else begin
      start_gate_q <= start_gate;
    end
  end

  // a decision is due when the count reaches the end of the current slot
  assign decide = state == SARC_CONV && bit_index < 5'h10 &&
    cycle_count == slot_edge(bit_index);
  // the last slot ends on the last counted cycle, so no bit is left undecided
  assign last_cycle = cycle_count == 16'(CONV_CYCLES - 1);

  // bipolar parts code the offset sample as two's complement
  assign cmp_value = BIPOLAR ? {~held_sample[15], held_sample[14:0]} : held_sample;
  assign trial = approx_result_reg | (16'h8000 >> bit_index);

  // conversion sequencer: idle, a fixed run of counted cycles, one cycle to
  // load the output latches, then idle again; starts are ignored outside idle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= SARC_IDLE;
    end else begin
      case (state)
        SARC_IDLE: begin
          if (take_start) begin
            state <= SARC_CONV;
          end
        end
        SARC_CONV: begin
          if (last_cycle) begin
            state <= SARC_DONE;
          end
        end
        SARC_DONE: begin
          state <= SARC_IDLE;
        end
        default: begin
          state <= SARC_IDLE;
        end
      endcase
    end
  end

  // conversion clock count; held at zero outside a conversion, so every
  // conversion lasts the same number of edges whatever came before
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cycle_count <= 16'h0000;
    end else if (state == SARC_CONV) begin
      cycle_count <= cycle_count + 16'h0001;
    end else begin
      cycle_count <= 16'h0000;
    end
  end

  // bit pointer, msb first; it stops at sixteen so no decision repeats
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bit_index <= 5'h00;
    end else if (take_start) begin
      bit_index <= 5'h00;
    end else if (decide) begin
      bit_index <= bit_index + 5'h01;
    end
  end

  // approximation register: cleared at the start, then each trial bit is
  // kept only while the trial does not exceed cmp_value, the held sample with its msb inverted when BIPOLAR is set
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      approx_result_reg <= 16'h0000;
    end else if (take_start) begin
      approx_result_reg <= 16'h0000;
    end else if (decide && trial <= cmp_value) begin
      approx_result_reg <= trial;
    end
  end

  // sample taken on the start edge; later input movement cannot reach the
  // result, as with the hold of a real sampler
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      held_sample <= 16'h0000;
    end else if (take_start) begin
      held_sample <= sample_in;
    end
  end

  // output latches load on the same edge that busy rises and reach the lanes one edge
  // later, so a host that reads on the rising busy edge still gets the old word
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      result_latch <= `SARC_RESULT_RST;
    end else if (state == SARC_DONE) begin
      result_latch <= approx_result_reg;
    end
  end

  // busy low from the start edge until the latch load has happened; it is
  // combinational so it falls in the cycle the gate falls. a gate still low
  // at the busy rise starts nothing until it rises and falls again
  assign bus.busy_n = !take_start && state == SARC_IDLE;
  // the sampler holds from the cycle after busy falls until busy rises
  assign sample_hold = state != SARC_IDLE;

  // read port: drives when chip select low and convert select high; a low
  // convert select always floats the lanes, whatever chip select does.
  // the lane register follows byte select one edge late
  assign bus.data_oe = ~bus.cs_n & bus.read_conv;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus.data_out <= 16'h0000;
    end else begin
      bus.data_out <= lane_order(result_latch, bus.byte_sel);
    end
  end
endmodule : sarc_device
`default_nettype wire

// ---- rtl/sarc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sarc_map.svh"
module sarc_host
  import sarc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // converter side
  sarc_if.host bus,
  // user side
  input wire logic go,
  input wire logic use_cs,
  input wire logic two_byte,
  output logic ready,
  output logic [`SARC_WIDTH-1:0] result,
  output logic result_valid
);
  sarc_host_state_type state;
  logic [15:0] count;
  logic busy_q;
  logic phase;

  // controller for both modes; pulses are counted, not timed by the device
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= SARC_H_IDLE;
      count <= 16'h0000;
      bus.cs_n <= 1'b1;
      bus.read_conv <= 1'b1;
      bus.byte_sel <= 1'b0;
      result <= 16'h0000;
      result_valid <= 1'b0;
      busy_q <= 1'b1;
      phase <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      busy_q <= bus.busy_n;
      case (state)
        SARC_H_IDLE: begin
          if (go) begin
            // select low first; in chip select mode it leads by the setup count
            bus.read_conv <= 1'b0;
            bus.cs_n <= ~use_cs ? 1'b0 : 1'b1;
            count <= 16'h0000;
            state <= SARC_H_START;
          end
        end
        SARC_H_START: begin
          count <= count + 16'h0001;
          if (use_cs && count == 16'(`SARC_SETUP_CYC - 1)) begin
            bus.cs_n <= 1'b0;
          end
          // hold both low for the start width, then release well inside 3us
          if (count == 16'(`SARC_SETUP_CYC + `SARC_START_CYC)) begin
            bus.read_conv <= 1'b1;
            bus.cs_n <= 1'b1;
            state <= SARC_H_WAIT;
          end
        end
        SARC_H_WAIT: begin
          // selects are already high at busy rise, so no restart
          if (bus.busy_n && !busy_q) begin
            bus.cs_n <= 1'b0;
            bus.byte_sel <= 1'b0;
            phase <= 1'b0;
            count <= 16'h0000;
            state <= SARC_H_READ;
          end
        end
        SARC_H_READ: begin
          count <= count + 16'h0001;
          // data registered one cycle after the enable; sample after two
          if (count == 16'h0002) begin
            if (!two_byte) begin
              result <= bus.data_bus;
            end else if (!phase) begin
              result[15:8] <= bus.data_bus[15:8];
            end else begin
              result[7:0] <= bus.data_bus[15:8];
            end
            if (two_byte && !phase) begin
              bus.byte_sel <= 1'b1;
              phase <= 1'b1;
              count <= 16'h0000;
            end else begin
              bus.cs_n <= 1'b1;
              bus.byte_sel <= 1'b0;
              result_valid <= 1'b1;
              count <= 16'h0000;
              state <= SARC_H_ACQ;
            end
          end
        end
        SARC_H_ACQ: begin
          count <= count + 16'h0001;
          if (count == 16'(`SARC_ACQ_CYC - 1)) begin
            state <= SARC_H_IDLE;
          end
        end
        default: begin
          state <= SARC_H_IDLE;
        end
      endcase
    end
  end

  assign ready = state == SARC_H_IDLE;
endmodule : sarc_host
`default_nettype wire

// ---- sim/sarc_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module sarc_props
  import sarc_pkg::*;
#(
  parameter int CONV_CYCLES = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // interface signals
  input wire logic cs_n,
  input wire logic read_conv,
  input wire logic byte_sel,
  input wire logic busy_n,
  input wire sarc_word_type data_out,
  input wire logic data_oe
);
  // latest busy rise after its fall: the start cycle, the counted run and the latch load
  localparam int END_MAX = CONV_CYCLES + 2;
  int low_cnt;
  // edges seen with busy low, so the length of a conversion can be bounded
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= busy_n ? 0 : low_cnt + 1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_lanes_off;
    !read_conv |-> !data_oe;
  endproperty
  a_lanes_off: assert property (p_lanes_off) else $error("lanes driven in convert");
  property p_read_on;
    !cs_n && read_conv |-> data_oe;
  endproperty
  a_read_on: assert property (p_read_on) else $error("lanes not driven on read");
  property p_start;
    $fell(cs_n | read_conv) && $past(busy_n) |-> !busy_n;
  endproperty
  a_start: assert property (p_start) else $error("busy missed a start");
  property p_gate;
    $fell(busy_n) |-> !cs_n && !read_conv;
  endproperty
  a_gate: assert property (p_gate) else $error("start with a select high");
  property p_hold;
    !busy_n && low_cnt < CONV_CYCLES |=> !busy_n;
  endproperty
  a_hold: assert property (p_hold) else $error("conversion cut short");
  property p_len;
    $rose(busy_n) |-> low_cnt >= CONV_CYCLES && low_cnt <= CONV_CYCLES + 2;
  endproperty
  a_len: assert property (p_len) else $error("conversion length wrong");
  property p_ends;
    $fell(busy_n) |-> ##[1:END_MAX] busy_n;
  endproperty
  a_ends: assert property (p_ends) else $error("busy never returned");
  property p_swap_up;
    $rose(byte_sel) && busy_n |=> data_out[15:8] == $past(data_out[7:0]);
  endproperty
  a_swap_up: assert property (p_swap_up) else $error("low byte not moved up");
  property p_swap_back;
    $fell(byte_sel) && busy_n |=> data_out[7:0] == $past(data_out[15:8]);
  endproperty
  a_swap_back: assert property (p_swap_back) else $error("byte order not restored");
endmodule : sarc_props
`default_nettype wire

// ---- sim/sar_adc_conversion_read_control_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_read_control_tb_top;
  import sarc_pkg::*;
  localparam int CONV = 32;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic use_cs = 1'b0;
  logic two_byte = 1'b0;
  logic ready;
  logic result_valid;
  sarc_word_type result;
  sarc_word_type result_bip;
  logic sample_hold;
  sarc_word_type sample_in = 16'h0000;
  sarc_word_type vals [4] = '{16'h0000, 16'hffff, 16'h8001, 16'h5aa5};
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  sarc_if bus_if();
  sarc_device #(.CONV_CYCLES(CONV)) sarc_device_inst(.clock(clock), .rst_n(rst_n),
    .bus(bus_if), .sample_in(sample_in), .sample_hold(sample_hold));
  // second pair with two's complement coding, run in step with the first
  if (1) begin : g_bipolar
    sarc_if bipolar_if();
    sarc_device #(.CONV_CYCLES(CONV), .BIPOLAR(1'b1)) sarc_device_inst(.clock(clock),
      .rst_n(rst_n), .bus(bipolar_if), .sample_in(sample_in), .sample_hold());
    sarc_host sarc_host_inst(.clock(clock), .rst_n(rst_n), .bus(bipolar_if), .go(go),
      .use_cs(use_cs), .two_byte(two_byte), .ready(), .result(result_bip),
      .result_valid());
  end
  sarc_host sarc_host_inst(.clock(clock), .rst_n(rst_n), .bus(bus_if), .go(go),
    .use_cs(use_cs), .two_byte(two_byte), .ready(ready), .result(result),
    .result_valid(result_valid));
  sarc_props #(.CONV_CYCLES(CONV)) sarc_props_inst(.clock(clock), .rst_n(rst_n),
    .cs_n(bus_if.cs_n), .read_conv(bus_if.read_conv), .byte_sel(bus_if.byte_sel),
    .busy_n(bus_if.busy_n), .data_out(bus_if.data_out), .data_oe(bus_if.data_oe));
  // 125 MHz clock
  initial forever #4 clock = ~clock;
  task automatic check(string what, sarc_word_type seen, sarc_word_type exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // one conversion and read; every wait is bounded, the timeout catches the rest
  task automatic convert(logic cs_mode, logic bytes, sarc_word_type v);
    int n;
    @(negedge clock);
    sample_in = v;
    use_cs = cs_mode;
    two_byte = bytes;
    go = 1'b1;
    n = 0;
    while (bus_if.busy_n !== 1'b0 && n < 50) begin
      @(negedge clock);
      n++;
    end
    go = 1'b0;
    // the start is taken on the edge after busy falls; move the input only then
    @(negedge clock);
    // value is held from the start, so a later input change must not leak in
    sample_in = ~v;
    check("hold", 16'(sample_hold), 16'h0001);
    check("lanes", bus_if.data_bus, 16'h0000);
    check("lanes enable", 16'(bus_if.data_oe), 16'h0000);
    n = 0;
    while (result_valid !== 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    check("result", result, v);
    check("result bipolar", result_bip, {~v[15], v[14:0]});
    n = 0;
    while (ready !== 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    check("ready", 16'(ready), 16'h0001);
  endtask : convert
  // both start modes, word and byte reads, boundary codes
  initial begin
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 4; k++) begin
        convert(m[1], m[0], vals[k]);
      end
    end
    tally_and_finish();
  end
  // hang guard, sized well above sixteen conversions
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
endmodule : sar_adc_conversion_read_control_tb_top
`default_nettype wire
